// ==== mbi_pkg.sv ====
// Shared constants for the packet buffer and MAC set-up block and its serial host.
package mbi_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int OSC_WAIT_NS   = 100000;
  localparam int OSC_WAIT_CYC  = (OSC_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] OSC_LAST = 16'(OSC_WAIT_CYC - 1);
  localparam int LINK_HALF_CYC = 4;       // Half link clock period, 800 ns period.
  localparam logic [4:0] FRAME_BITS = 5'h10;

  // ****************************************************************
  // Packet memory
  // ****************************************************************
  localparam int PTR_W          = 13;
  localparam int TX_STATUS_BYTES = 7;
  localparam logic [2:0] TX_STATUS_LAST = 3'(TX_STATUS_BYTES - 1);

  // ****************************************************************
  // Device register offsets on the serial port
  // ****************************************************************
  localparam logic [6:0] ADDR_RXST_L  = 7'h00;
  localparam logic [6:0] ADDR_RXST_H  = 7'h01;
  localparam logic [6:0] ADDR_RXND_L  = 7'h02;
  localparam logic [6:0] ADDR_RXND_H  = 7'h03;
  localparam logic [6:0] ADDR_RDPT_L  = 7'h04;
  localparam logic [6:0] ADDR_RDPT_H  = 7'h05;
  localparam logic [6:0] ADDR_WRPT_L  = 7'h06;
  localparam logic [6:0] ADDR_WRPT_H  = 7'h07;
  localparam logic [6:0] ADDR_MAC1    = 7'h08;
  localparam logic [6:0] ADDR_MAC3    = 7'h09;
  localparam logic [6:0] ADDR_MAC4    = 7'h0A;
  localparam logic [6:0] ADDR_MAXFL_L = 7'h0B;
  localparam logic [6:0] ADDR_MAXFL_H = 7'h0C;
  localparam logic [6:0] ADDR_B2B     = 7'h0D;
  localparam logic [6:0] ADDR_NB2B_L  = 7'h0E;
  localparam logic [6:0] ADDR_NB2B_H  = 7'h0F;
  localparam logic [6:0] ADDR_RETX    = 7'h10;
  localparam logic [6:0] ADDR_COLWIN  = 7'h11;
  localparam logic [6:0] ADDR_STATUS  = 7'h12;
  localparam int NREG = 18;
  localparam int CMD_WR_BIT = 15;

  // ****************************************************************
  // Fields and values
  // ****************************************************************
  localparam int MAC1_RXEN_BIT    = 0;
  localparam int MAC1_KEEP_CONTROL_FRAMES_BIT_BIT = 1;
  localparam int MAC1_PAUSE_RX_ENABLE_BIT_BIT  = 2;
  localparam int MAC1_PAUSE_TX_ENABLE_BIT_BIT  = 3;
  localparam logic [7:0] MAC1_MASK = 8'h0F;
  localparam logic [7:0] PTR_H_MASK = 8'h1F;
  localparam int MAC3_PAD_POS     = 5;
  localparam int MAC3_CRC_BIT     = 4;
  localparam int MAC3_FRMLN_BIT   = 1;
  localparam int MAC3_FDX_BIT     = 0;
  localparam logic [2:0] PAD_60_CRC = 3'h1;
  localparam int MAC4_WAIT_MEDIUM_IDLE_BIT_BIT   = 6;
  localparam int STATUS_OSC_BIT   = 0;
  localparam logic [15:0] MAX_FRAME_LEN = 16'h05EE;
  localparam logic [7:0] B2B_FDX   = 8'h15;
  localparam logic [7:0] B2B_HDX   = 8'h12;
  localparam logic [7:0] NB2B_LOW  = 8'h12;
  localparam logic [7:0] NB2B_HIGH = 8'h0C;
  localparam logic [7:0] RETX_DEFAULT   = 8'h00;
  localparam logic [7:0] COLWIN_DEFAULT = 8'h00;
  localparam logic [4:0] INIT_LAST_STEP = 5'h0F;

  // ****************************************************************
  // Host command port offsets
  // ****************************************************************
  localparam logic [1:0] HOST_DATA  = 2'h0;
  localparam logic [1:0] HOST_GO    = 2'h1;
  localparam logic [1:0] HOST_STAT  = 2'h2;
  localparam logic [1:0] HOST_RDATA = 2'h3;

endpackage

// ==== mbi_link_if.sv ====
// Serial register link between the host controller and the device.
`timescale 1ns/100ps
interface mbi_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport host (output sclk, output cs_n, output mosi, input miso);
  modport dev  (input sclk, input cs_n, input mosi, output miso);
endinterface

// ==== mbi_sync.sv ====
// Two flip-flop synchroniser for pins arriving from another clock.
`timescale 1ns/100ps
module mbi_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } mbi_sync_s;
  mbi_sync_s q;
  mbi_sync_s d;

  // The first stage feeds only the second stage.
  always_comb
  begin
    d.s1 = d_in;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      q <= '{s1: RST_VAL, s2: RST_VAL};
    else
      q <= d;
  end

  assign q_out = q.s2;
endmodule

// ==== mbi_dev.sv ====
// Device end: receive ring pointers, status vector writes and MAC control one.
`timescale 1ns/100ps
// What this block does
// - Start through end reserved for receive writes.
// - Host programs an even receive start.
// - Start or end write reloads hidden pointer.
// - Visible write pointer moves on good packets.
// - Host writes read pointer low, then high.
// - Memory outside receive region is transmit space.
// - Seven status bytes follow each sent packet.
// - Host waits for oscillator ready before MAC.
// - MAC set-up writes accepted in any order.
// - Bit 0 enables MAC reception.
// - Bit 1 keeps received control frames.
// - Bit 2 lets pause frames stop sending.
// - Bit 3 permits sending pause frames.
// - Bits 7 to 4 read zero.
// - Maximum frame length register, normally 1518.
// - Back-to-back gap 15h full, 12h half.
// - Non-back-to-back gap low byte 12h.
// - Half duplex: gap high byte 0Ch.
// - Half duplex: retry and collision window set.
// - Full duplex bit only for full-duplex partner.
// - Set the deferral bit in control four.
// - Pad to 60 bytes and append CRC.
module mbi_dev
  import mbi_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  mbi_link_if.dev                link,
  input  wire logic              rx_valid_in,
  input  wire logic [7:0]        rx_data_in,
  input  wire logic              rx_last_in,
  input  wire logic              rx_good_in,
  input  wire logic              rx_ctrl_in,
  input  wire logic              rx_pause_in,
  input  wire logic              pause_tx_req_in,
  input  wire logic              tx_done_in,
  input  wire logic [PTR_W-1:0]  tx_last_addr_in,
  input  wire logic [55:0]       tx_status_in,
  output logic                   mem_we_out,
  output logic      [PTR_W-1:0]  mem_addr_out,
  output logic      [7:0]        mem_wdata_out,
  output logic                   pause_stop_out,
  output logic                   pause_tx_go_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic                     osc_rdy;
    logic [15:0]              osc_cnt;
    logic                     sclk_prev;
    logic [4:0]               bit_cnt;
    logic [7:0]               sh_in;
    logic [7:0]               cmd;
    logic [7:0]               sh_out;
    logic                     miso;
    logic [NREG-1:0][7:0]     regs;
    logic [PTR_W-1:0]         rd_ptr;
    logic [PTR_W-1:0]         wr_hidden;
    logic [PTR_W-1:0]         wr_vis;
    logic [PTR_W-1:0]         frame_base;
    logic                     in_frame;
    logic                     keep;
    logic                     ovf;
    logic                     tx_busy;
    logic [2:0]               tx_idx;
    logic [PTR_W-1:0]         tx_addr;
    logic [55:0]              tx_vec;
    logic                     mem_we;
    logic [PTR_W-1:0]         mem_addr;
    logic [7:0]               mem_wdata;
    logic                     pause_stop;
    logic                     pause_tx_go;
  } mbi_dev_s;

  mbi_dev_s   q;
  mbi_dev_s   d;
  logic [2:0] pin_s;

  // Link pins come from the host's clock, so all three pass the synchroniser.
  mbi_sync #(
    .W       (3),
    .RST_VAL (3'h2)
  ) u_pin_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .d_in   ({link.sclk, link.cs_n, link.mosi}),
    .q_out  (pin_s)
  );

  // ****************************************************************
  // Register read mux
  // ****************************************************************
  function automatic logic [7:0] reg_read(input mbi_dev_s s, input logic [6:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      ADDR_WRPT_L: v = s.wr_vis[7:0];
      ADDR_WRPT_H: v = {3'h0, s.wr_vis[PTR_W-1:8]};
      ADDR_RDPT_L: v = s.rd_ptr[7:0];
      ADDR_RDPT_H: v = {3'h0, s.rd_ptr[PTR_W-1:8]};
      ADDR_MAC1:   v = s.regs[ADDR_MAC1] & MAC1_MASK;
      ADDR_STATUS: v = {7'h00, s.osc_rdy};
      default:     v = (a < 7'(NREG)) ? s.regs[a[4:0]] : 8'h00;
    endcase
    return v;
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic             rise;
  logic             fall;
  logic [7:0]       wbyte;
  logic [6:0]       waddr;
  logic [PTR_W-1:0] rx_start;
  logic [PTR_W-1:0] rx_end;
  logic [PTR_W-1:0] next_ptr;
  logic [PTR_W-1:0] base_cur;
  logic             keeping;
  logic             ovf_cur;
  logic             accept;
  logic [7:0]       mac1;

  always_comb
  begin
    d              = q;
    d.mem_we       = 1'b0;
    d.pause_stop   = 1'b0;
    mac1           = q.regs[ADDR_MAC1];
    rise           = pin_s[2] & ~q.sclk_prev;
    fall           = ~pin_s[2] & q.sclk_prev;
    wbyte          = {q.sh_in[6:0], pin_s[0]};
    waddr          = q.cmd[6:0];
    d.sclk_prev    = pin_s[2];
    keeping        = 1'b0;
    ovf_cur        = 1'b0;
    accept         = 1'b0;
    base_cur       = q.frame_base;

    // The ready flag keeps software off the MAC until the start-up wait ends.
    if (!q.osc_rdy)
    begin
      d.osc_cnt = q.osc_cnt + 16'h0001;
      if (q.osc_cnt == OSC_LAST)
        d.osc_rdy = 1'b1;
    end

    // Serial slave: command byte, then a data byte in or out.
    if (pin_s[1])
      d.bit_cnt = 5'h00;
    else if (rise && q.bit_cnt < FRAME_BITS)
    begin
      d.sh_in   = wbyte;
      d.bit_cnt = q.bit_cnt + 5'h01;
      if (q.bit_cnt == 5'h07)
      begin
        d.cmd    = wbyte;
        d.sh_out = reg_read(q, wbyte[6:0]);
        d.miso   = d.sh_out[7];
      end
      // Writes land in any order, except that the read pointer needs its low byte written before the high byte.
      if (q.bit_cnt == 5'h0F && q.cmd[7])
      begin
        if (waddr < 7'(NREG) && waddr != ADDR_WRPT_L && waddr != ADDR_WRPT_H)
        begin
          unique case (waddr)
            ADDR_MAC1:   d.regs[waddr[4:0]] = wbyte & MAC1_MASK;
            ADDR_RXST_H,
            ADDR_RXND_H,
            ADDR_RDPT_H: d.regs[waddr[4:0]] = wbyte & PTR_H_MASK;
            default:     d.regs[waddr[4:0]] = wbyte;
          endcase
        end
        // Only the hidden copy moves; the visible pointer waits for a packet.
        if (waddr <= ADDR_RXND_H)
          d.wr_hidden = {d.regs[ADDR_RXST_H][4:0], d.regs[ADDR_RXST_L]};
        // The read pointer commits on the high byte so both halves change together.
        if (waddr == ADDR_RDPT_H)
          d.rd_ptr = {wbyte[4:0], q.regs[ADDR_RDPT_L]};
      end
    end
    else if (fall && q.bit_cnt >= 5'h09 && q.bit_cnt < FRAME_BITS)
    begin
      d.sh_out = {q.sh_out[6:0], 1'b0};
      d.miso   = q.sh_out[6];
    end

    // Receive ring: bytes go only between start and end inclusive.
    rx_start = {q.regs[ADDR_RXST_H][4:0], q.regs[ADDR_RXST_L]};
    rx_end   = {q.regs[ADDR_RXND_H][4:0], q.regs[ADDR_RXND_L]};
    next_ptr = (q.wr_hidden == rx_end) ? rx_start : q.wr_hidden + 13'h0001;
    if (rx_valid_in)
    begin
      if (!q.in_frame)
      begin
        d.in_frame   = 1'b1;
        keeping      = mac1[MAC1_RXEN_BIT];
        d.keep       = keeping;
        base_cur     = q.wr_hidden;
        d.frame_base = q.wr_hidden;
      end
      else
      begin
        keeping = q.keep;
        ovf_cur = q.ovf;
      end
      // Stop one short of the read pointer so unread packets stay intact.
      if (keeping && !ovf_cur)
      begin
        if (next_ptr == q.rd_ptr)
          ovf_cur = 1'b1;
        else
        begin
          d.mem_we    = 1'b1;
          d.mem_addr  = q.wr_hidden;
          d.mem_wdata = rx_data_in;
          d.wr_hidden = next_ptr;
        end
      end
      d.ovf = ovf_cur;
      if (rx_last_in)
      begin
        d.in_frame = 1'b0;
        accept = rx_good_in && !ovf_cur &&
                 !(rx_ctrl_in && !mac1[MAC1_KEEP_CONTROL_FRAMES_BIT_BIT]);
        if (keeping && accept)
          d.wr_vis = d.wr_hidden;
        else if (keeping)
          d.wr_hidden = base_cur;
        if (keeping && rx_good_in && rx_pause_in && mac1[MAC1_PAUSE_RX_ENABLE_BIT_BIT])
          d.pause_stop = 1'b1;
      end
    end

    // Status vector after a sent packet; anywhere outside the ring is allowed.
    if (tx_done_in && !q.tx_busy)
    begin
      d.tx_busy = 1'b1;
      d.tx_idx  = 3'h0;
      d.tx_addr = tx_last_addr_in + 13'h0001;
      d.tx_vec  = tx_status_in;
    end
    else if (q.tx_busy && !d.mem_we)
    begin
      // Receive bytes take the port first; they cannot be held off.
      d.mem_we    = 1'b1;
      d.mem_addr  = q.tx_addr;
      d.mem_wdata = q.tx_vec[7:0];
      d.tx_vec    = {8'h00, q.tx_vec[55:8]};
      d.tx_addr   = q.tx_addr + 13'h0001;
      d.tx_idx    = q.tx_idx + 3'h1;
      if (q.tx_idx == TX_STATUS_LAST)
        d.tx_busy = 1'b0;
    end

    d.pause_tx_go = pause_tx_req_in & mac1[MAC1_PAUSE_TX_ENABLE_BIT_BIT];
  end

  // All registers clear on reset, including the MAC set-up registers.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      q <= '0;
    else
      q <= d;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign link.miso       = q.miso;
  assign mem_we_out      = q.mem_we;
  assign mem_addr_out    = q.mem_addr;
  assign mem_wdata_out   = q.mem_wdata;
  assign pause_stop_out  = q.pause_stop;
  assign pause_tx_go_out = q.pause_tx_go;

endmodule

// ==== mbi_host.sv ====
// Host end: start-up configuration sequence and a software command port.
`timescale 1ns/100ps
module mbi_host
  import mbi_pkg::*;
#(
  parameter logic [PTR_W-1:0] RX_START    = 13'h0000,
  parameter logic [PTR_W-1:0] RX_END      = 13'h0FFF,
  parameter bit               FULL_DUPLEX = 1'b0,
  parameter int               HALF_CYC    = LINK_HALF_CYC
) (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  mbi_link_if.host        link,
  input  wire logic [1:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out
);

  // An odd start or an empty ring cannot be served; a short half period races the sync.
  if (RX_START[0] || RX_START > RX_END || HALF_CYC < 4 || HALF_CYC > 127)
  begin : g_bad_param
    $error("mbi_host parameters out of range");
  end

  localparam logic [7:0] HLAST = 8'(HALF_CYC - 1);
  localparam logic [7:0] FLAST = 8'(2 * HALF_CYC - 1);

  typedef enum logic [1:0] {ST_POLL, ST_CFG, ST_READY} mbi_host_e;

  typedef struct packed {
    mbi_host_e   st;
    logic [4:0]  step;
    logic        run;
    logic [7:0]  cnt;
    logic [4:0]  bits;
    logic [15:0] tx;
    logic [7:0]  rx;
    logic        sclk;
    logic        cs_n;
    logic        mosi;
    logic [7:0]  data;
    logic [7:0]  rdata;
    logic [7:0]  rdout;
  } mbi_host_s;

  localparam mbi_host_s HOST_RST = '{st: ST_POLL, cs_n: 1'b1, default: '0};

  mbi_host_s q;
  mbi_host_s d;
  logic      miso_s;

  mbi_sync #(
    .W       (1),
    .RST_VAL (1'b0)
  ) u_miso_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .d_in   (link.miso),
    .q_out  (miso_s)
  );

  // ****************************************************************
  // Start-up table: {write, address, data} per step, skip flag returned separately
  // ****************************************************************
  function automatic logic [15:0] init_step(input logic [4:0] i, output logic skip);
    logic [6:0] a;
    logic [7:0] v;
    skip = 1'b0;
    a    = ADDR_RXST_L;
    v    = RX_START[7:0];
    unique case (i)
      5'h00: begin a = ADDR_RXST_L; v = RX_START[7:0]; end
      5'h01: begin a = ADDR_RXST_H; v = {3'h0, RX_START[12:8]}; end
      5'h02: begin a = ADDR_RXND_L; v = RX_END[7:0]; end
      5'h03: begin a = ADDR_RXND_H; v = {3'h0, RX_END[12:8]}; end
      5'h04: begin a = ADDR_RDPT_L; v = RX_START[7:0]; end
      5'h05: begin a = ADDR_RDPT_H; v = {3'h0, RX_START[12:8]}; end
      5'h06:
      begin
        a = ADDR_MAC1;
        v = 8'h01 << MAC1_RXEN_BIT;
        if (FULL_DUPLEX)
          v = v | (8'h01 << MAC1_PAUSE_TX_ENABLE_BIT_BIT) | (8'h01 << MAC1_PAUSE_RX_ENABLE_BIT_BIT);
      end
      5'h07:
      begin
        a = ADDR_MAC3;
        v = {PAD_60_CRC, 5'h00} | (8'h01 << MAC3_CRC_BIT) | (8'h01 << MAC3_FRMLN_BIT);
        if (FULL_DUPLEX)
          v = v | (8'h01 << MAC3_FDX_BIT);
      end
      5'h08: begin a = ADDR_MAC4; v = 8'h01 << MAC4_WAIT_MEDIUM_IDLE_BIT_BIT; end
      5'h09: begin a = ADDR_MAXFL_L; v = MAX_FRAME_LEN[7:0]; end
      5'h0A: begin a = ADDR_MAXFL_H; v = MAX_FRAME_LEN[15:8]; end
      5'h0B: begin a = ADDR_B2B; v = FULL_DUPLEX ? B2B_FDX : B2B_HDX; end
      5'h0C: begin a = ADDR_NB2B_L; v = NB2B_LOW; end
      5'h0D: begin a = ADDR_NB2B_H; v = NB2B_HIGH; skip = FULL_DUPLEX; end
      5'h0E: begin a = ADDR_RETX; v = RETX_DEFAULT; skip = FULL_DUPLEX; end
      default: begin a = ADDR_COLWIN; v = COLWIN_DEFAULT; skip = FULL_DUPLEX; end
    endcase
    return {1'b1, a, v};
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic        launch;
  logic        done;
  logic        skip;
  logic [15:0] word;
  logic [15:0] step_word;

  always_comb
  begin
    d         = q;
    d.rdout   = 8'h00;
    launch    = 1'b0;
    done      = 1'b0;
    word      = 16'h0000;
    step_word = init_step(q.step, skip);

    // Shift engine: one bit per link period, then one idle period with select high.
    if (q.run)
    begin
      d.cnt = q.cnt + 8'h01;
      if (q.cnt == HLAST && q.bits < FRAME_BITS)
        d.sclk = 1'b1;
      if (q.cnt == FLAST)
      begin
        // Sampling late in the high phase leaves room for both synchronisers.
        d.cnt  = 8'h00;
        d.sclk = 1'b0;
        d.bits = q.bits + 5'h01;
        if (q.bits < FRAME_BITS)
        begin
          d.rx   = {q.rx[6:0], miso_s};
          d.tx   = {q.tx[14:0], 1'b0};
          d.mosi = q.tx[14];
        end
        if (q.bits == FRAME_BITS - 5'h01)
          d.cs_n = 1'b1;
        if (q.bits == FRAME_BITS)
        begin
          d.run = 1'b0;
          done  = 1'b1;
        end
      end
    end

    unique case (q.st)
      ST_POLL:
        if (done)
        begin
          if (q.rx[STATUS_OSC_BIT])
            d.st = ST_CFG;
        end
        else if (!q.run)
        begin
          launch = 1'b1;
          word   = {1'b0, ADDR_STATUS, 8'h00};
        end
      ST_CFG:
        if (done || (!q.run && skip))
        begin
          if (q.step == INIT_LAST_STEP)
            d.st = ST_READY;
          else
            d.step = q.step + 5'h01;
        end
        else if (!q.run)
        begin
          launch = 1'b1;
          word   = step_word;
        end
      ST_READY:
      begin
        if (done)
          d.rdata = q.rx;
        if (reg_wr_in && reg_addr_in == HOST_GO && !q.run)
        begin
          launch = 1'b1;
          word   = {reg_wdata_in, q.data};
        end
      end
    endcase

    if (launch)
    begin
      d.run  = 1'b1;
      d.tx   = word;
      d.mosi = word[15];
      d.cs_n = 1'b0;
      d.bits = 5'h00;
      d.cnt  = 8'h00;
      d.sclk = 1'b0;
    end

    // Command port: data byte, go byte, status and last read byte.
    if (reg_wr_in && reg_addr_in == HOST_DATA)
      d.data = reg_wdata_in;
    if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        HOST_DATA:  d.rdout = q.data;
        HOST_GO:    d.rdout = 8'h00;
        HOST_STAT:  d.rdout = {6'h00, q.st == ST_READY, q.run};
        HOST_RDATA: d.rdout = q.rdata;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      q <= HOST_RST;
    else
      q <= d;
  end

  assign link.sclk     = q.sclk;
  assign link.cs_n     = q.cs_n;
  assign link.mosi     = q.mosi;
  assign reg_rdata_out = q.rdout;

endmodule

// ==== mbi_link_sva.sv ====
// Checker on the serial link and the device's memory and pause outputs.
`timescale 1ns/100ps
module mbi_link_sva
  import mbi_pkg::*;
#(
  parameter logic [12:0] RX_START = 13'h0000,
  parameter logic [12:0] RX_END   = 13'h0FFF
) (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        sclk,
  input wire logic        cs_n,
  input wire logic        rx_valid_in,
  input wire logic        rx_last_in,
  input wire logic        rx_pause_in,
  input wire logic        pause_tx_req_in,
  input wire logic        tx_done_in,
  input wire logic [12:0] tx_last_addr_in,
  input wire logic        mem_we_out,
  input wire logic [12:0] mem_addr_out,
  input wire logic        pause_stop_out,
  input wire logic        pause_tx_go_out
);
  // ****
  // Properties
  // ****
  // One clock domain, so nothing is judged while reset is high.
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  a_idle_clock_low: assert property (cs_n |-> !sclk) else $error("link clock high when idle");
  a_frame_gap: assert property ($rose(cs_n) |=> cs_n [*7]) else $error("frame gap too short");
  a_sclk_high_half: assert property ($rose(sclk) |=> sclk [*3] ##1 !sclk)
    else $error("link clock high phase wrong");
  a_rx_in_region: assert property ($past(rx_valid_in) && mem_we_out |->
    mem_addr_out >= RX_START && mem_addr_out <= RX_END) else $error("receive write outside");
  a_rx_wrap_start: assert property (rx_valid_in ##1 rx_valid_in && mem_we_out
    && mem_addr_out == RX_END |=> mem_we_out && mem_addr_out == RX_START)
    else $error("no wrap to start");
  a_tx_status_seven: assert property (tx_done_in && !rx_valid_in ##1 !rx_valid_in
    |=> mem_we_out && mem_addr_out == $past(tx_last_addr_in, 2) + 13'h1
    ##1 mem_we_out [*6] ##1 !mem_we_out) else $error("status writes wrong");
  a_pause_stop_cause: assert property (pause_stop_out |-> $past(rx_valid_in)
    && $past(rx_last_in) && $past(rx_pause_in)) else $error("pause stop without cause");
  a_pause_go_cause: assert property (pause_tx_go_out |-> $past(pause_tx_req_in))
    else $error("pause send without request");
endmodule

// ==== mac_buffer_init_config_test.sv ====
// Bench: host and device joined by the link, driven through the command port.
`timescale 1ns/100ps
module mac_buffer_init_config_test
  import mbi_pkg::*;
;
  // ****
  // Bench
  // ****
  logic        clk_in = 1'b0, rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic        rx_valid_in = 1'b0, rx_last_in = 1'b0, rx_ctrl_in = 1'b0, rx_pause_in = 1'b0;
  logic        rx_good_in = 1'b1, tx_done_in = 1'b0, pause_tx_req_in = 1'b0;
  logic        mem_we_out, pause_stop_out, pause_tx_go_out;
  logic [1:0]  reg_addr_in = 2'h0;
  logic [7:0]  reg_wdata_in = 8'h00, rx_data_in = 8'h00, reg_rdata_out, mem_wdata_out, r, last_d;
  logic [12:0] tx_last_addr_in = 13'h0000, mem_addr_out, last_a;
  logic [55:0] tx_status_in = 56'h0;
  int          num_errors = 0, tests_run = 0, nwr = 0, nstop = 0, nwr0 = 0;
  // Read-back after start-up: register offset in the high byte, value in the low byte.
  logic [15:0] tbl [10] = '{16'h0801, 16'h0932, 16'h0A40, 16'h0BEE, 16'h0D12, 16'h0E12,
    16'h0F0C, 16'h0700, 16'h1201, 16'h1300};
  mbi_link_if link ();
  mbi_host #(.RX_START(13'h0100), .RX_END(13'h0107)) mbi_host_i (.*);
  mbi_dev mbi_dev_i (.*);
  mbi_link_sva #(.RX_START(13'h0100), .RX_END(13'h0107)) mbi_link_sva_i
    (.sclk(link.sclk), .cs_n(link.cs_n), .*);
  // Free-running 10 MHz clock.
  initial forever #50 clk_in = ~clk_in;
  // Count memory writes and pause pulses, keeping the last write seen.
  always @(posedge clk_in)
  begin
    nwr <= nwr + int'(mem_we_out);
    nstop <= nstop + int'(pause_stop_out);
    if (mem_we_out)
    begin
      last_a <= mem_addr_out;
      last_d <= mem_wdata_out;
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One command port cycle; read data is taken in the cycle after the strobe.
  task automatic bus(input logic rd, input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= !rd;
    reg_rd_in <= rd;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    #1 r = reg_rdata_out;
  endtask
  // A whole link frame; the status poll is bounded so a dead link cannot hang here.
  task automatic acc(input logic wr, input logic [6:0] a, input logic [7:0] d);
    bus(1'b0, HOST_DATA, d);
    bus(1'b0, HOST_GO, {wr, a});
    for (int k = 0; k < 400 && r !== 8'h02; k++)
      bus(1'b1, HOST_STAT, 8'h00);
    chk(r, 16'h0002);
    bus(1'b1, HOST_RDATA, 8'h00);
  endtask
  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(r, e);
  endtask
  // Received frame of n back-to-back bytes; status comes from rx_good_in as the caller set it.
  task automatic frame(input int n, input logic c, input logic p);
    for (int k = 0; k < n; k++)
    begin
      @(posedge clk_in);
      rx_valid_in <= 1'b1;
      rx_data_in <= 8'(k);
      rx_last_in <= (k == n - 1);
      rx_ctrl_in <= c;
      rx_pause_in <= p;
    end
    @(posedge clk_in);
    rx_valid_in <= 1'b0;
    rx_last_in <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Start-up takes about 3500 cycles and the scenarios under 10000 more.
  initial
  begin
    repeat (40000) @(posedge clk_in);
    num_errors++;
    tally_and_finish();
  end
  // Start-up, then the scenarios in turn on the running pair.
  initial
  begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int k = 0; k < 9000 && r !== 8'h02; k++)
      bus(1'b1, HOST_STAT, 8'h00);
    chk(r, 16'h0002);
    foreach (tbl[k])
      rdc(tbl[k][14:8], tbl[k][7:0]);
    pause_tx_req_in <= 1'b1;
    acc(1'b1, ADDR_MAC1, 8'hF0);
    rdc(ADDR_MAC1, 8'h00);
    nwr0 = nwr;
    frame(2, 1'b0, 1'b0);
    chk(16'(nwr - nwr0), 16'h0000);
    chk(pause_tx_go_out, 16'h0000);
    acc(1'b1, ADDR_MAC1, 8'hFF);
    rdc(ADDR_MAC1, 8'h0F);
    chk(pause_tx_go_out, 16'h0001);
    frame(4, 1'b0, 1'b0);
    chk(last_a, 16'h0103);
    rdc(ADDR_WRPT_L, 8'h04);
    frame(2, 1'b1, 1'b1);
    chk(16'(nstop), 16'h0001);
    rdc(ADDR_WRPT_L, 8'h06);
    acc(1'b1, ADDR_RDPT_L, 8'h05);
    acc(1'b1, ADDR_RDPT_H, 8'h01);
    frame(6, 1'b0, 1'b0);
    chk(last_a, 16'h0103);
    acc(1'b1, ADDR_RXST_L, 8'h02);
    rdc(ADDR_WRPT_L, 8'h04);
    frame(1, 1'b0, 1'b0);
    chk(last_a, 16'h0102);
    // Bad status and a discarded control frame both leave the visible pointer alone.
    acc(1'b1, ADDR_MAC1, 8'h09);
    rx_good_in <= 1'b0;
    frame(1, 1'b0, 1'b0);
    rx_good_in <= 1'b1;
    frame(1, 1'b1, 1'b1);
    chk(16'(nstop), 16'h0001);
    rdc(ADDR_WRPT_L, 8'h03);
    #1 nwr0 = nwr;
    @(posedge clk_in);
    tx_last_addr_in <= 13'h1FF0;
    tx_status_in <= 56'hA6A5A4A3A2A1A0;
    tx_done_in <= 1'b1;
    @(posedge clk_in);
    tx_done_in <= 1'b0;
    repeat (12) @(posedge clk_in);
    chk(16'(nwr - nwr0), 16'h0007);
    chk(last_a, 16'h1FF7);
    chk(last_d, 16'h00A6);
    tally_and_finish();
  end
endmodule
